// ---- ncm_pkg.sv ----
/*
 * Shared constants, carrier types and helper functions for the non-cached
 * processor memory control block.
 * Assumes one rising-edge system clock shared by the processor and memory.
 */
package ncm_pkg;

    localparam int unsigned ADDR_W       = 32;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned CHIP_AW      = 14;      // 16K words per ram device
    localparam int unsigned CHIP_DW      = 16;      // 16 data bits per ram device
    localparam int unsigned CHIP_BYTES   = 2;
    localparam int unsigned BANK_SEL_LSB = 14;      // address bit that picks a bank
    localparam int unsigned BANK_SEL_W   = 2;       // up to four instruction banks
    localparam int unsigned DBANKS       = 2;       // 2 x 16K words = 128 KB of data
    localparam int unsigned IBANKS_DEF   = 2;       // 128 KB of instructions
    localparam int unsigned IBANKS_MAX   = 4;       // 256 KB of instructions

    // transfer size code
    localparam logic [1:0] SIZE_BYTE   = 2'h0;
    localparam logic [1:0] SIZE_HALF   = 2'h1;
    localparam logic [1:0] SIZE_WORD   = 2'h2;
    localparam logic [1:0] SIZE_DOUBLE = 2'h3;

    localparam logic [3:0] LANES_NONE  = 4'h0;
    localparam logic [3:0] LANES_ALL   = 4'hF;

    // unlatched bus cycle, presented one cycle ahead of its use
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [1:0]        size;
        logic              wrt;    // next cycle writes memory
        logic              rd;     // next cycle reads memory
        logic              dxfer;  // next cycle is a data (not fetch) cycle
    } ncm_bus_t;

    // instruction memory loading port of the external agent
    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ncm_load_t;

    typedef enum logic [1:0] {
        CYC_IDLE,
        CYC_FETCH,
        CYC_LOAD,
        CYC_STORE
    } ncm_cyc_t;

    localparam ncm_bus_t BUS_IDLE = '{addr: 32'h0, size: 2'h0, wrt: 1'b0, rd: 1'b0, dxfer: 1'b0};

    // big-endian lanes: lane 3 is bits 31:24 at byte offset 0; misaligned gives none
    function automatic logic [3:0] byte_lanes(input logic [1:0] lo, input logic [1:0] size);
        logic [3:0] be;
        be = LANES_NONE;
        case (size)
            SIZE_BYTE: be = 4'h1 << (2'h3 - lo);
            SIZE_HALF: begin
                if (!lo[0]) be = lo[1] ? 4'h3 : 4'hC;
            end
            default:   begin
                if (lo == 2'h0) be = LANES_ALL;
            end
        endcase
        return be;
    endfunction

    function automatic logic [BANK_SEL_W-1:0] bank_of(input logic [ADDR_W-1:0] a);
        return a[BANK_SEL_LSB +: BANK_SEL_W];
    endfunction

    // word index inside a bank, bank select bits taken out
    function automatic logic [CHIP_AW-1:0] chip_index(input logic [ADDR_W-1:0] a);
        return {a[BANK_SEL_LSB+BANK_SEL_W +: 2], a[BANK_SEL_LSB-1:2]};
    endfunction

endpackage

// ---- ncm_sram16.sv ----
/*
 * One 16K x 16 synchronous ram device: registered address and byte write
 * enables, self-timed byte write in the following cycle, asynchronous
 * output enable.  Assumes write data stands during the cycle after the
 * address and enables were presented.
 */
`timescale 1ns/10ps
module ncm_sram16 (
    input  wire logic                       clk_i,
    input  wire logic                       reset_n_i,
    input  wire logic [ncm_pkg::CHIP_AW-1:0] addr_i,
    input  wire logic [ncm_pkg::CHIP_BYTES-1:0] byte_we_i,
    input  wire logic [ncm_pkg::CHIP_DW-1:0] wdata_i,
    input  wire logic                       cancel_i,
    input  wire logic                       oe_i,
    output logic      [ncm_pkg::CHIP_DW-1:0] rdata_o
);
    localparam int unsigned DEPTH = 1 << ncm_pkg::CHIP_AW;

    logic [ncm_pkg::CHIP_DW-1:0]    mem_q [DEPTH];
    logic [ncm_pkg::CHIP_AW-1:0]    addr_q;
    logic [ncm_pkg::CHIP_BYTES-1:0] we_q;

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            addr_q <= '0;
            we_q   <= '0;
        end else begin
            addr_q <= addr_i;
            we_q   <= byte_we_i;
        end
    end

    // array has no reset: contents survive a clocked reset
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < ncm_pkg::CHIP_BYTES; b++) begin
            if (we_q[b] && !cancel_i) begin
                mem_q[addr_q][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
        end
    end

    assign rdata_o = oe_i ? mem_q[addr_q] : '0;

endmodule // ncm_sram16

// ---- ncm_bus_latch.sv ----
/*
 * Input register for the processor's unlatched bus cycle and the decode of
 * the cycle kind that the latched fields call for.
 * Assumes the processor drives the bus one cycle ahead on the same clock.
 */
`timescale 1ns/10ps
module ncm_bus_latch (
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    input  wire ncm_pkg::ncm_bus_t bus_i,
    output ncm_pkg::ncm_bus_t      bus_q_o,
    output ncm_pkg::ncm_cyc_t      kind_o
);
    ncm_pkg::ncm_bus_t bus_q;
    ncm_pkg::ncm_cyc_t kind_q;
    ncm_pkg::ncm_cyc_t kind_d;

    always_comb begin
        if (bus_i.wrt) begin
            kind_d = ncm_pkg::CYC_STORE;
        end else if (bus_i.rd) begin
            kind_d = bus_i.dxfer ? ncm_pkg::CYC_LOAD : ncm_pkg::CYC_FETCH;
        end else begin
            kind_d = ncm_pkg::CYC_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            bus_q  <= ncm_pkg::BUS_IDLE;
            kind_q <= ncm_pkg::CYC_IDLE;
        end else begin
            bus_q  <= bus_i;
            kind_q <= kind_d;
        end
    end

    assign bus_q_o = bus_q;
    assign kind_o  = kind_q;

endmodule // ncm_bus_latch

// ---- ncm_mem_ctrl.sv ----
/*
 * Memory control for a non-cached processor memory: data and instruction
 * banks of 16K x 16 ram devices, byte write enables, output enables and
 * the fetch size check, all with no wait states.
 * Assumes the processor shares clk_i, drives its bus one cycle ahead, and
 * an external agent loads instruction memory before the processor runs.
 */
// Chosen here: strobed register access and the placing of the registers.
// Notes on behaviour
// - bus fields arrive one cycle early; memory registers them before use
// - instruction fetch data is on the data bus in the use cycle
// - nullify in the use cycle cancels that access
// - single load: instruction slot, then one cycle returning the word
// - double load adds one cycle returning the second word
// - store data stands in the second cycle; memory updates then
// - double store adds a cycle, address plus 4, size code 11
// - rams register address and enables, self-timed byte writes, async enable
// - every bus cycle is served with no wait state
// - processor cannot write instruction memory; external agent loads it
// - 128 KB data, 128 KB instruction, instruction expandable to 256 KB
// - each ram device is 16K words of 16 bits, common data pins
// - size code: 00 byte, 01 half, 10 word, 11 double; fetch uses word
// - address bit 14 picks the lower or upper data bank
`timescale 1ns/10ps
module ncm_mem_ctrl #(
    parameter int unsigned IBANKS = ncm_pkg::IBANKS_DEF
) (
    input  wire logic                      clk_i,
    input  wire logic                      reset_n_i,
    input  wire ncm_pkg::ncm_bus_t         bus_i,
    input  wire logic [ncm_pkg::DATA_W-1:0] store_data_i,
    input  wire logic                      cycle_nullify_i,
    input  wire ncm_pkg::ncm_load_t        load_i,
    output logic      [ncm_pkg::DATA_W-1:0] data_o,
    output logic                           data_oe_o,
    output logic                           ifetch_exc_o,
    output logic      [IBANKS-1:0]         ibank_oe_o,
    output logic      [ncm_pkg::DBANKS-1:0] dbank_oe_o
);
    localparam int unsigned DCHIPS = 2 * ncm_pkg::DBANKS;
    localparam int unsigned ICHIPS = 2 * IBANKS;

    ncm_pkg::ncm_bus_t              bus_q;
    ncm_pkg::ncm_cyc_t              kind;
    logic [ncm_pkg::DATA_W-1:0]     load_data_q;
    logic [3:0]                     store_lanes;
    logic                           fetch_ok;
    logic                           load_ok;
    logic [ncm_pkg::CHIP_DW-1:0]    drd [DCHIPS];
    logic [ncm_pkg::CHIP_DW-1:0]    ird [ICHIPS];
    logic [ncm_pkg::CHIP_AW-1:0]    iaddr;
    logic [ncm_pkg::BANK_SEL_W-1:0] ibank_wr;

    ncm_bus_latch u_latch (
        .clk_i     (clk_i),
        .reset_n_i (reset_n_i),
        .bus_i     (bus_i),
        .bus_q_o   (bus_q),
        .kind_o    (kind)
    );

    // loader data rides with its address; registered here so it follows by one cycle, like a processor store
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            load_data_q <= '0;
        end else begin
            load_data_q <= load_i.data;
        end
    end

    // misaligned stores get no lanes and so never touch memory
    assign store_lanes = bus_i.wrt ? ncm_pkg::byte_lanes(bus_i.addr[1:0], bus_i.size)
                                   : ncm_pkg::LANES_NONE;

    // a double access is just two word cycles here
    assign fetch_ok = (kind == ncm_pkg::CYC_FETCH) && (bus_q.size == ncm_pkg::SIZE_WORD)
                      && !cycle_nullify_i;
    assign load_ok  = (kind == ncm_pkg::CYC_LOAD) && !cycle_nullify_i;

    assign ifetch_exc_o = (kind == ncm_pkg::CYC_FETCH) && (bus_q.size != ncm_pkg::SIZE_WORD);

    always_comb begin
        ibank_oe_o = '0;
        dbank_oe_o = '0;
        case (kind)
            ncm_pkg::CYC_FETCH: begin
                for (int g = 0; g < IBANKS; g++) begin
                    ibank_oe_o[g] = fetch_ok && (ncm_pkg::bank_of(bus_q.addr) == g[1:0]);
                end
            end
            ncm_pkg::CYC_LOAD: begin
                for (int g = 0; g < ncm_pkg::DBANKS; g++) begin
                    dbank_oe_o[g] = load_ok && (bus_q.addr[ncm_pkg::BANK_SEL_LSB] == g[0]);
                end
            end
            default: begin
                ibank_oe_o = '0;
                dbank_oe_o = '0;
            end
        endcase
    end

    assign data_oe_o = fetch_ok || load_ok;

    // data banks: written only by processor stores
    for (genvar c = 0; c < DCHIPS; c++) begin : g_dchip
        localparam logic [1:0]  BANK = 2'(c / 2);
        localparam int unsigned HALF = c % 2;
        logic [1:0]             we;
        assign we = (bus_i.addr[ncm_pkg::BANK_SEL_LSB] == BANK[0])
                    ? store_lanes[2*HALF +: 2] : 2'h0;
        ncm_sram16 u_ram (
            .clk_i     (clk_i),
            .reset_n_i (reset_n_i),
            .addr_i    (ncm_pkg::chip_index(bus_i.addr)),
            .byte_we_i (we),
            .wdata_i   (store_data_i[16*HALF +: 16]),
            .cancel_i  (cycle_nullify_i),
            .oe_i      (dbank_oe_o[c/2]),
            .rdata_o   (drd[c])
        );
    end

    // instruction banks: the loader owns the port while it writes
    assign iaddr    = load_i.we ? ncm_pkg::chip_index(load_i.addr) : ncm_pkg::chip_index(bus_i.addr);
    assign ibank_wr = ncm_pkg::bank_of(load_i.addr);

    for (genvar c = 0; c < ICHIPS; c++) begin : g_ichip
        localparam logic [1:0]  BANK = 2'(c / 2);
        localparam int unsigned HALF = c % 2;
        logic [1:0]             we;
        // no processor term reaches these enables
        assign we = (load_i.we && (ibank_wr == BANK)) ? 2'h3 : 2'h0;
        ncm_sram16 u_ram (
            .clk_i     (clk_i),
            .reset_n_i (reset_n_i),
            .addr_i    (iaddr),
            .byte_we_i (we),
            .wdata_i   (load_data_q[16*HALF +: 16]),
            .cancel_i  (1'b0),
            .oe_i      (ibank_oe_o[c/2]),
            .rdata_o   (ird[c])
        );
    end

    // disabled devices read as zero, so the bus is a plain or
    always_comb begin
        data_o = '0;
        for (int c = 0; c < DCHIPS; c++) begin
            data_o[16*(c%2) +: 16] = data_o[16*(c%2) +: 16] | drd[c];
        end
        for (int c = 0; c < ICHIPS; c++) begin
            data_o[16*(c%2) +: 16] = data_o[16*(c%2) +: 16] | ird[c];
        end
    end

endmodule // ncm_mem_ctrl

// ---- ncm_ctrl_sva.sv ----
/* Port checker for the memory control block.
   Assumes one clock domain and a bind onto ncm_mem_ctrl. */
`timescale 1ns/10ps
module ncm_ctrl_sva #(
    parameter int unsigned IBANKS = 2
) (
    input wire logic                       clk_i,
    input wire logic                       reset_n_i,
    input wire ncm_pkg::ncm_bus_t          bus_i,
    input wire logic                       cycle_nullify_i,
    input wire logic                       data_oe_o,
    input wire logic                       ifetch_exc_o,
    input wire logic [IBANKS-1:0]          ibank_oe_o,
    input wire logic [ncm_pkg::DBANKS-1:0] dbank_oe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    sequence ok_fetch_s; bus_i.rd && !bus_i.dxfer && !bus_i.wrt && bus_i.size == ncm_pkg::SIZE_WORD; endsequence
    sequence bad_fetch_s; bus_i.rd && !bus_i.dxfer && !bus_i.wrt && bus_i.size != ncm_pkg::SIZE_WORD; endsequence
    sequence load_s; bus_i.rd && bus_i.dxfer && !bus_i.wrt; endsequence
    fetch_drive_a: assert property (ok_fetch_s ##1 !cycle_nullify_i |->
        data_oe_o && $onehot(ibank_oe_o) && dbank_oe_o == '0) else $error("fetch not served");
    fetch_exc_a: assert property (bad_fetch_s |=> ifetch_exc_o && !data_oe_o)
        else $error("bad fetch size not flagged");
    load_bank_a: assert property (load_s ##1 !cycle_nullify_i |-> data_oe_o && ibank_oe_o == '0 &&
        dbank_oe_o == (2'h1 << $past(bus_i.addr[14]))) else $error("load bank wrong");
    nullify_mute_a: assert property (cycle_nullify_i |-> !data_oe_o)
        else $error("nullified cycle drove data");
    store_quiet_a: assert property (bus_i.wrt |=> !data_oe_o && !ifetch_exc_o)
        else $error("store cycle drove data");
    idle_quiet_a: assert property (!bus_i.rd && !bus_i.wrt |=> !data_oe_o && ibank_oe_o == '0)
        else $error("idle cycle drove data");
    double_load_a: assert property (load_s ##1 (load_s and !cycle_nullify_i) ##1 !cycle_nullify_i
        |-> data_oe_o && $past(data_oe_o)) else $error("double load stalled");
    reset_idle_a: assert property (disable iff (1'b0) !reset_n_i |=>
        !data_oe_o && !ifetch_exc_o && ibank_oe_o == '0 && dbank_oe_o == '0) else $error("reset not idle");
endmodule // ncm_ctrl_sva
bind ncm_mem_ctrl ncm_ctrl_sva #(.IBANKS(IBANKS)) u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i),
    .cycle_nullify_i(cycle_nullify_i), .data_oe_o(data_oe_o), .ifetch_exc_o(ifetch_exc_o),
    .ibank_oe_o(ibank_oe_o), .dbank_oe_o(dbank_oe_o));

// ---- ncm_cpu_model.sv ----
/* Processor bus model: each cycle presented one clock ahead.
   Assumes the bench calls step once per cycle. */
`timescale 1ns/10ps
module ncm_cpu_model (
    input  wire logic         clk_i,
    output ncm_pkg::ncm_bus_t bus_o,
    output logic [31:0]       store_data_o,
    output logic              cycle_nullify_o
);
    initial begin
        bus_o = ncm_pkg::BUS_IDLE;
        store_data_o = 32'h0;
        cycle_nullify_o = 1'b0;
    end
    // one call per clock, so a locked pair is never split
    task automatic step(input ncm_pkg::ncm_bus_t nxt, input logic [31:0] d, input logic dv, input logic nul);
        @(posedge clk_i);
        bus_o <= nxt;
        store_data_o <= dv ? d : ~store_data_o;
        cycle_nullify_o <= nul;
        @(negedge clk_i);
    endtask
endmodule // ncm_cpu_model

// ---- tb.sv ----
/* Self-checking bench: loads instruction memory, then runs fetches, stores
   and loads back to back. Assumes a 100 MHz clock. */
`timescale 1ns/10ps
module tb;
    localparam ncm_pkg::ncm_cyc_t F = ncm_pkg::CYC_FETCH, L = ncm_pkg::CYC_LOAD, S = ncm_pkg::CYC_STORE;
    localparam logic [1:0] B = ncm_pkg::SIZE_BYTE, H = ncm_pkg::SIZE_HALF, W = ncm_pkg::SIZE_WORD;
    localparam logic [1:0] D = ncm_pkg::SIZE_DOUBLE;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    ncm_pkg::ncm_load_t load_i = '0;
    ncm_pkg::ncm_bus_t bus_i;
    logic [31:0] store_data_i, data_o, pa = 32'h0, pd = 32'h0;
    logic [31:0] mem [32768];
    logic [31:0] imem [32768];
    logic data_oe_o, ifetch_exc_o, cycle_nullify_i, pn = 1'b0;
    logic [1:0] ibank_oe_o, dbank_oe_o, ps = 2'h0;
    ncm_pkg::ncm_cyc_t pk = ncm_pkg::CYC_IDLE;
    int bad_count = 0;
    int tests_run = 0;
    always #5 clk_i = ~clk_i;
    ncm_mem_ctrl #(.IBANKS(2)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i),
        .store_data_i(store_data_i), .cycle_nullify_i(cycle_nullify_i), .load_i(load_i), .data_o(data_o),
        .data_oe_o(data_oe_o), .ifetch_exc_o(ifetch_exc_o), .ibank_oe_o(ibank_oe_o), .dbank_oe_o(dbank_oe_o));
    ncm_cpu_model u_cpu (.clk_i(clk_i), .bus_o(bus_i), .store_data_o(store_data_i),
        .cycle_nullify_o(cycle_nullify_i));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    function automatic logic [31:0] lanes(input logic [1:0] lo, input logic [1:0] sz);
        case (sz)
            B: return 32'hFF000000 >> (8 * lo);
            H: return lo[0] ? 32'h0 : (32'hFFFF0000 >> (8 * lo));
            default: return (lo == 2'h0) ? 32'hFFFFFFFF : 32'h0;
        endcase
    endfunction
    task automatic ld(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk_i);
        // loader data rides with its address; the block delays it one cycle itself
        load_i <= '{we: 1'b1, addr: a, data: d};
        @(posedge clk_i);
        load_i <= '{we: 1'b0, addr: ~a, data: ~d};
        imem[a[16:2]] = d;
    endtask
    // issue one cycle; checks land on the use cycle of the one before
    task automatic go(input ncm_pkg::ncm_cyc_t k, input logic [31:0] a, input logic [1:0] sz,
                      input logic [31:0] d, input logic n);
        logic oe;
        logic [31:0] m;
        u_cpu.step('{addr: a, size: sz, wrt: k == S, rd: k inside {F, L}, dxfer: k != F}, pd, pk == S, pn);
        oe = !pn && (pk == L || (pk == F && ps == W));
        chk("data_oe", 32'(oe), 32'(data_oe_o));
        chk("fetch_exc", 32'(pk == F && ps != W), 32'(ifetch_exc_o));
        if (!pn) begin
            chk("ibank_oe", (oe && pk == F) ? 32'h1 << pa[14] : 32'h0, 32'(ibank_oe_o));
            chk("dbank_oe", (oe && pk == L) ? 32'h1 << pa[14] : 32'h0, 32'(dbank_oe_o));
        end
        if (oe) chk("data", (pk == F) ? imem[pa[16:2]] : mem[pa[16:2]], data_o);
        if (pk == S && !pn) begin
            m = lanes(pa[1:0], ps);
            mem[pa[16:2]] = (mem[pa[16:2]] & ~m) | (pd & m);
        end
        pk = k; pa = a; ps = sz; pd = d; pn = n;
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #100000;
        bad_count++;
        final_report;
    end
    initial begin
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        chk("reset_idle", 32'h0, 32'({data_oe_o, ifetch_exc_o, ibank_oe_o, dbank_oe_o}));
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        $display("test reset done");
        ld(32'h0, 32'h13579BDF);
        ld(32'h4004, 32'h2468ACE0);
        go(S, 32'h0, W, 32'hDEADBEEF, 1'b0);
        go(F, 32'h0, W, 32'h0, 1'b0);
        go(F, 32'h4004, W, 32'h0, 1'b0);
        go(F, 32'h0, B, 32'h0, 1'b0);
        go(F, 32'h4004, W, 32'h0, 1'b1);
        $display("test fetch done");
        go(S, 32'h10, W, 32'h01234567, 1'b0);
        go(S, 32'h4010, W, 32'h89ABCDEF, 1'b0);
        go(S, 32'h20, D, 32'hCAFEF00D, 1'b0);
        go(S, 32'h24, D, 32'h0BADBEEF, 1'b0);
        for (int i = 0; i < 3; i++) go(S, 32'h10 + i, B, 32'h11111111 * (i + 1), 1'b0);
        go(S, 32'h4012, H, 32'h5A5A5A5A, 1'b0);
        go(S, 32'h4011, H, 32'hFFFFFFFF, 1'b0);
        go(S, 32'h20, W, 32'h0, 1'b1);
        go(L, 32'h10, W, 32'h0, 1'b0);
        go(L, 32'h4010, W, 32'h0, 1'b0);
        go(L, 32'h20, D, 32'h0, 1'b0);
        go(L, 32'h24, D, 32'h0, 1'b0);
        go(F, 32'h0, W, 32'h0, 1'b0);
        go(ncm_pkg::CYC_IDLE, 32'h0, W, 32'h0, 1'b0);
        $display("test store load done");
        final_report;
    end
endmodule // tb
